/* rtl/rstc_defines.svh */
/*
  Constants of the system reset controller: source bit positions, reset values and timing counts.
  Assumes it is included by its bare name from the reset controller files and the bench.
*/
`ifndef RSTC_DEFINES_SVH
`define RSTC_DEFINES_SVH

`define RSTC_SRC_COUNT 8
`define RSTC_SRC_POR 0
`define RSTC_SRC_PIN 1
`define RSTC_SRC_CMP 2
`define RSTC_SRC_SW 3
`define RSTC_SRC_SMON 4
`define RSTC_SRC_WDOG 5
`define RSTC_SRC_MCD 6
`define RSTC_SRC_FLASH 7
`define RSTC_SRC_NONE 8'h00
`define RSTC_CAUSE_POR 8'h01
`define RSTC_RESET_VECTOR 16'h0000
`define RSTC_WDOG_TIMEOUT_MAX 3'h7
`define RSTC_SETTLE_CYCLES 3
`define RSTC_SETTLE_LOAD 2'h2

`endif

/* rtl/rstc_pkg.sv */
/*
  Types of the system reset controller.
  Assumes nothing beyond the constants header.
*/
package rstc_pkg;
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_HOLD = 4'h2,
        ST_SETTLE = 4'h4,
        ST_EXIT = 4'h8
    } rstc_state_t;
    typedef logic [7:0] rstc_src_t;
endpackage : rstc_pkg

/* rtl/rstc_src_gather.sv */
/*
  Gathers the reset sources; pin-side sources pass a two-flop synchroniser.
  Assumes software, watchdog, clock-loss and flash requests come from system-clock logic.
*/
`timescale 1ns/1ps
`include "rstc_defines.svh"
module rstc_src_gather (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // asynchronous sources
    input wire logic reset_pin_n_in,
    input wire logic cmp_req_in,
    input wire logic smon_req_in,
    // synchronous sources
    input wire logic sw_req_in,
    input wire logic wdog_req_in,
    input wire logic mcd_req_in,
    input wire logic flash_req_in,
    // gathered requests
    rstc_src_if.src src
);
    logic [2:0] raw;
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [2:0] meta_next;
    logic [2:0] sync_next;

    assign raw = {smon_req_in, cmp_req_in, ~reset_pin_n_in};

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_sync
            always_comb begin
                meta_next[i] = raw[i];
                sync_next[i] = meta_reg[i];
            end
            always_ff @(posedge clk_sys_in) begin
                if (!nrst_in) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= meta_next[i];
                    sync_reg[i] <= sync_next[i];
                end
            end
        end
    endgenerate

    // power-on is the controller's own reset, so its bit stays clear here
    always_comb begin
        src.req = `RSTC_SRC_NONE;
        src.req[`RSTC_SRC_PIN] = sync_reg[0];
        src.req[`RSTC_SRC_CMP] = sync_reg[1];
        src.req[`RSTC_SRC_SMON] = sync_reg[2];
        src.req[`RSTC_SRC_SW] = sw_req_in;
        src.req[`RSTC_SRC_WDOG] = wdog_req_in;
        src.req[`RSTC_SRC_MCD] = mcd_req_in;
        src.req[`RSTC_SRC_FLASH] = flash_req_in;
    end
endmodule : rstc_src_gather

/* rtl/rstc_src_if.sv */
/*
  Carrier of the gathered reset requests between source gatherer and controller.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface rstc_src_if;
    rstc_pkg::rstc_src_t req;
    modport src (output req);
    modport ctl (input req);
endinterface : rstc_src_if

/* rtl/system_reset_controller.sv */
/*
  System reset controller: merges reset sources, holds core and peripherals in reset,
  drives the reset pin for power-on and supply resets and performs the reset exit.
  Assumes nrst_in is the power-on reset, synchronous to clk_sys_in, and that the
  port, analog, clock and watchdog blocks obey the level and pulse outputs.
*/
`timescale 1ns/1ps
`include "rstc_defines.svh"
module system_reset_controller #(
    parameter int PORT_W = 8
) (
    // clock and power-on reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // reset sources
    input wire logic reset_pin_n_in,
    input wire logic cmp_req_in,
    input wire logic smon_req_in,
    input wire logic sw_req_in,
    input wire logic wdog_req_in,
    input wire logic mcd_req_in,
    input wire logic flash_req_in,
    // firmware retention enable
    input wire logic retain_en_in,
    // reset pin drive
    output logic reset_pin_n_out,
    output logic reset_pin_n_oe_n_out,
    // core and module reset
    output logic core_halt_out,
    output logic periph_rst_n_out,
    output logic por_rst_n_out,
    output logic irq_timer_disable_out,
    output logic ram_protect_out,
    // port and analog state
    output logic port_force_default_out,
    output logic [PORT_W-1:0] port_latch_default_out,
    output logic port_open_drain_out,
    output logic port_pullup_out,
    output logic analog_retain_out,
    // reset exit
    output logic pc_clear_out,
    output logic [15:0] reset_vector_out,
    output logic clk_internal_out,
    output logic wdog_enable_out,
    output logic [2:0] wdog_timeout_sel_out,
    // status
    output logic [7:0] reset_cause_out
);
    localparam int SETTLE_MAX = 4;

    rstc_src_if src_bus ();

    rstc_src_gather u_gather (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .reset_pin_n_in(reset_pin_n_in),
        .cmp_req_in(cmp_req_in),
        .smon_req_in(smon_req_in),
        .sw_req_in(sw_req_in),
        .wdog_req_in(wdog_req_in),
        .mcd_req_in(mcd_req_in),
        .flash_req_in(flash_req_in),
        .src(src_bus.src)
    );

    rstc_pkg::rstc_state_t state_reg, state_next;
    rstc_pkg::rstc_src_t cause_reg, cause_next, eff_req;
    logic drive_reg, drive_next;
    logic retain_reg, retain_next;
    logic [1:0] settle_reg, settle_next;
    logic any_req, in_reset_next;
    logic halt_next, irq_next, port_def_next, ana_next, exit_next;

    // own pin drive would reset us again; the pin is ignored while driven and settling
    always_comb begin
        eff_req = src_bus.req;
        if (drive_reg || state_reg == rstc_pkg::ST_SETTLE) begin
            eff_req[`RSTC_SRC_PIN] = 1'b0;
        end
        any_req = |eff_req;
    end

    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        unique case (state_reg)
            rstc_pkg::ST_RUN: begin
                if (any_req) begin
                    state_next = rstc_pkg::ST_HOLD;
                end
            end
            rstc_pkg::ST_HOLD: begin
                if (!any_req) begin
                    state_next = drive_reg ? rstc_pkg::ST_SETTLE : rstc_pkg::ST_EXIT;
                    settle_next = `RSTC_SETTLE_LOAD;
                end
            end
            rstc_pkg::ST_SETTLE: begin
                if (any_req) begin
                    state_next = rstc_pkg::ST_HOLD;
                end else if (settle_reg == 2'h0) begin
                    // pin still low after our drive stopped: someone else holds it
                    state_next = src_bus.req[`RSTC_SRC_PIN] ? rstc_pkg::ST_HOLD
                                                             : rstc_pkg::ST_EXIT;
                end else begin
                    settle_next = settle_reg - 2'h1;
                end
            end
            rstc_pkg::ST_EXIT: begin
                state_next = any_req ? rstc_pkg::ST_HOLD : rstc_pkg::ST_RUN;
            end
        endcase
    end

    always_comb begin
        in_reset_next = state_next == rstc_pkg::ST_HOLD || state_next == rstc_pkg::ST_SETTLE;
        // watchdog and the other sources never set the drive
        drive_next = state_next == rstc_pkg::ST_HOLD &&
                     (drive_reg || eff_req[`RSTC_SRC_SMON]);
        cause_next = cause_reg;
        if (state_reg == rstc_pkg::ST_RUN && any_req) begin
            cause_next = eff_req;
        end else if (state_reg != rstc_pkg::ST_RUN) begin
            cause_next = cause_reg | eff_req;
        end
        retain_next = (state_reg == rstc_pkg::ST_RUN) ? retain_en_in : retain_reg;
        halt_next = state_next != rstc_pkg::ST_RUN;
        irq_next = in_reset_next;
        port_def_next = in_reset_next && !retain_next;
        ana_next = in_reset_next && retain_next;
        exit_next = state_next == rstc_pkg::ST_EXIT;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            state_reg <= rstc_pkg::ST_HOLD;
            settle_reg <= 2'h0;
            drive_reg <= 1'b1;
            cause_reg <= `RSTC_CAUSE_POR;
            retain_reg <= 1'b0;
            reset_pin_n_oe_n_out <= 1'b0;
            core_halt_out <= 1'b1;
            periph_rst_n_out <= 1'b0;
            por_rst_n_out <= 1'b0;
            irq_timer_disable_out <= 1'b1;
            ram_protect_out <= 1'b1;
            port_force_default_out <= 1'b1;
            analog_retain_out <= 1'b0;
            pc_clear_out <= 1'b0;
            clk_internal_out <= 1'b0;
            wdog_enable_out <= 1'b0;
            reset_cause_out <= `RSTC_CAUSE_POR;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
            drive_reg <= drive_next;
            cause_reg <= cause_next;
            retain_reg <= retain_next;
            reset_pin_n_oe_n_out <= !drive_next;
            core_halt_out <= halt_next;
            periph_rst_n_out <= !in_reset_next;
            por_rst_n_out <= 1'b1;
            irq_timer_disable_out <= irq_next;
            ram_protect_out <= in_reset_next;
            port_force_default_out <= port_def_next;
            analog_retain_out <= ana_next;
            pc_clear_out <= exit_next;
            clk_internal_out <= exit_next;
            wdog_enable_out <= exit_next;
            reset_cause_out <= cause_next;
        end
    end

    // constant drive values, still held in flops so every output is registered
    always_ff @(posedge clk_sys_in) begin
        reset_pin_n_out <= 1'b0;
        port_latch_default_out <= '1;
        port_open_drain_out <= 1'b1;
        port_pullup_out <= 1'b1;
        reset_vector_out <= `RSTC_RESET_VECTOR;
        wdog_timeout_sel_out <= `RSTC_WDOG_TIMEOUT_MAX;
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    sequence leave_reset_s;
        (state_reg == rstc_pkg::ST_HOLD || state_reg == rstc_pkg::ST_SETTLE)
            ##1 state_reg == rstc_pkg::ST_EXIT;
    endsequence

    sequence exit_pulse_s;
        pc_clear_out && clk_internal_out && wdog_enable_out ##1 !pc_clear_out;
    endsequence

    halt_in_reset_a: assert property (
        state_reg != rstc_pkg::ST_RUN |-> core_halt_out)
        else $error("core not halted in reset");
    entry_disable_a: assert property (
        state_reg == rstc_pkg::ST_RUN && any_req |=> irq_timer_disable_out && !periph_rst_n_out)
        else $error("reset entry did not disable modules");
    // power-on flop is still low on the first edge after nrst_in rises
    por_bits_kept_a: assert property (
        state_reg == rstc_pkg::ST_HOLD && $past(nrst_in) |-> por_rst_n_out && !periph_rst_n_out)
        else $error("power-on-only bits disturbed");
    ram_kept_a: assert property (
        $fell(periph_rst_n_out) |-> ram_protect_out)
        else $error("ram not protected in reset");
    port_default_a: assert property (
        state_reg == rstc_pkg::ST_HOLD && !retain_reg |-> port_force_default_out
            && port_open_drain_out && port_pullup_out && &port_latch_default_out)
        else $error("ports not at default in reset");
    retain_hold_a: assert property (
        state_reg == rstc_pkg::ST_HOLD && retain_reg |-> analog_retain_out
            && !port_force_default_out)
        else $error("retention not honoured");
    supply_drive_a: assert property (
        state_reg == rstc_pkg::ST_RUN && eff_req[`RSTC_SRC_SMON]
            |=> !reset_pin_n_oe_n_out && !reset_pin_n_out)
        else $error("supply reset not driving pin");
    wdog_no_pin_a: assert property (
        state_reg == rstc_pkg::ST_RUN && eff_req == 8'h20 |=> reset_pin_n_oe_n_out)
        else $error("watchdog reset drove pin");
    exit_actions_a: assert property (
        leave_reset_s |-> exit_pulse_s and (reset_vector_out == `RSTC_RESET_VECTOR))
        else $error("reset exit actions missing");
    wdog_default_a: assert property (
        wdog_enable_out |-> wdog_timeout_sel_out == `RSTC_WDOG_TIMEOUT_MAX)
        else $error("watchdog timeout not maximum");
    hold_while_req_a: assert property (
        state_reg == rstc_pkg::ST_HOLD && any_req |=> state_reg == rstc_pkg::ST_HOLD)
        else $error("released with source active");
    cause_capture_a: assert property (
        state_reg == rstc_pkg::ST_RUN && any_req |=> reset_cause_out == $past(eff_req))
        else $error("reset cause not captured");
    settle_bound_a: assert property (
        $rose(state_reg == rstc_pkg::ST_SETTLE) |-> ##[1:SETTLE_MAX]
            state_reg != rstc_pkg::ST_SETTLE)
        else $error("pin settle too long");
endmodule : system_reset_controller

/* tb/core_model.sv */
/*
  Core-side model: program counter, clock select, watchdog enable, one RAM word, reset pin.
  Assumes the level and pulse outputs of system_reset_controller on the same clock.
*/
`timescale 1ns/1ps
module core_model (
    // clock
    input wire logic clk_sys_in,
    // controller outputs
    input wire logic halt_in,
    input wire logic pc_clear_in,
    input wire logic [15:0] vector_in,
    input wire logic clk_int_in,
    input wire logic wdog_en_in,
    input wire logic ram_protect_in,
    input wire logic pin_drv_in,
    input wire logic pin_oe_n_in,
    // software and outside world
    input wire logic ext_pin_n_in,
    input wire logic sw_clk_ext_in,
    input wire logic sw_wdog_off_in,
    input wire logic ram_we_in,
    input wire logic [7:0] ram_wdata_in,
    // observed state
    output logic pin_n_out,
    output logic [15:0] first_fetch_out,
    output logic clk_int_out,
    output logic wdog_on_out,
    output logic [7:0] ram_out
);
    logic [15:0] pc_reg = 16'h1234;
    logic halt_d = 1'b0;
    initial first_fetch_out = 16'hFFFF;
    initial clk_int_out = 1'b0;
    initial wdog_on_out = 1'b0;
    initial ram_out = 8'h00;
    // open-drain pin with pull-up: low if anyone pulls it
    assign pin_n_out = ext_pin_n_in & (pin_oe_n_in | pin_drv_in);
    always @(posedge clk_sys_in) begin
        halt_d <= halt_in;
        if (pc_clear_in) begin
            pc_reg <= vector_in;
        end else if (!halt_in) begin
            pc_reg <= pc_reg + 16'h0001;
        end
        // stale fetch address is voided on reset entry
        if (!halt_d && halt_in) begin
            first_fetch_out <= 16'hFFFF;
        end else if (halt_d && !halt_in) begin
            first_fetch_out <= pc_reg;
        end
        if (clk_int_in) begin
            clk_int_out <= 1'b1;
        end else if (sw_clk_ext_in) begin
            clk_int_out <= 1'b0;
        end
        if (wdog_en_in) begin
            wdog_on_out <= 1'b1;
        end else if (sw_wdog_off_in) begin
            wdog_on_out <= 1'b0;
        end
        if (ram_we_in && !ram_protect_in) begin
            ram_out <= ram_wdata_in;
        end
    end
endmodule : core_model

/* tb/tb.sv */
/*
  Self-checking bench of the system reset controller with a core-side model.
  Assumes a 10 MHz clock and power-on reset on nrst_in.
*/
`timescale 1ns/1ps
`include "rstc_defines.svh"
module tb;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic cmp = 1'b0, smon = 1'b0, sw = 1'b0, wdog = 1'b0, mcd = 1'b0, flash = 1'b0;
    logic retain = 1'b0, ext_pin_n = 1'b1, clk_ext = 1'b0, wdog_off = 1'b0;
    logic ram_we = 1'b0;
    logic [7:0] ram_wdata = 8'h00;
    logic pin_n, pin_drv, oe_n, halt, prst_n, por_n, irq_dis, ram_prot, force_def;
    logic od, pu, ana_ret, pc_clr, clk_int, wdog_en, clk_int_m, wdog_on;
    logic [7:0] latch_def, cause, ram;
    logic [15:0] vector, first_fetch;
    logic [2:0] tsel;
    int fails = 0;
    int checked = 0;
    int sync_ids[4] = '{`RSTC_SRC_SW, `RSTC_SRC_WDOG, `RSTC_SRC_MCD, `RSTC_SRC_FLASH};
    int async_ids[3] = '{`RSTC_SRC_PIN, `RSTC_SRC_CMP, `RSTC_SRC_SMON};

    system_reset_controller dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .reset_pin_n_in(pin_n), .cmp_req_in(cmp), .smon_req_in(smon), .sw_req_in(sw),
        .wdog_req_in(wdog), .mcd_req_in(mcd), .flash_req_in(flash), .retain_en_in(retain),
        .reset_pin_n_out(pin_drv), .reset_pin_n_oe_n_out(oe_n), .core_halt_out(halt),
        .periph_rst_n_out(prst_n), .por_rst_n_out(por_n), .irq_timer_disable_out(irq_dis),
        .ram_protect_out(ram_prot), .port_force_default_out(force_def),
        .port_latch_default_out(latch_def), .port_open_drain_out(od), .port_pullup_out(pu),
        .analog_retain_out(ana_ret), .pc_clear_out(pc_clr), .reset_vector_out(vector),
        .clk_internal_out(clk_int), .wdog_enable_out(wdog_en),
        .wdog_timeout_sel_out(tsel), .reset_cause_out(cause));
    core_model core_u (.clk_sys_in(clk_sys_in), .halt_in(halt), .pc_clear_in(pc_clr),
        .vector_in(vector), .clk_int_in(clk_int), .wdog_en_in(wdog_en),
        .ram_protect_in(ram_prot), .pin_drv_in(pin_drv), .pin_oe_n_in(oe_n),
        .ext_pin_n_in(ext_pin_n), .sw_clk_ext_in(clk_ext), .sw_wdog_off_in(wdog_off),
        .ram_we_in(ram_we), .ram_wdata_in(ram_wdata), .pin_n_out(pin_n),
        .first_fetch_out(first_fetch), .clk_int_out(clk_int_m), .wdog_on_out(wdog_on),
        .ram_out(ram));

    initial begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask : chk

    task automatic final_report;
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic set_src(input int idx, input logic v);
        case (idx)
            `RSTC_SRC_PIN: ext_pin_n <= !v;
            `RSTC_SRC_CMP: cmp <= v;
            `RSTC_SRC_SW: sw <= v;
            `RSTC_SRC_SMON: smon <= v;
            `RSTC_SRC_WDOG: wdog <= v;
            `RSTC_SRC_MCD: mcd <= v;
            default: flash <= v;
        endcase
    endtask : set_src

    // software switches clock and watchdog off and stores a RAM byte
    task automatic mess_up(input logic [7:0] val);
        @(posedge clk_sys_in);
        clk_ext <= 1'b1;
        wdog_off <= 1'b1;
        ram_we <= 1'b1;
        ram_wdata <= val;
        @(posedge clk_sys_in);
        clk_ext <= 1'b0;
        wdog_off <= 1'b0;
        ram_we <= 1'b0;
    endtask : mess_up

    // bounded wait for halt release, then judge the exit state
    task automatic wait_run;
        int n;
        int pulses;
        n = 0;
        pulses = 0;
        // the exit pulse may already stand when called right after a clock edge
        #1;
        while (halt !== 1'b0 && n < 60) begin
            if (pc_clr === 1'b1 && clk_int === 1'b1 && wdog_en === 1'b1) pulses++;
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        chk(pulses == 1 && prst_n === 1'b1 && halt === 1'b0, "single exit pulse");
        @(posedge clk_sys_in);
        #1;
        chk(first_fetch === `RSTC_RESET_VECTOR, "first fetch address");
        chk(clk_int_m === 1'b1, "internal clock after exit");
        chk(wdog_on === 1'b1, "watchdog on after exit");
        chk(tsel === `RSTC_WDOG_TIMEOUT_MAX, "watchdog timeout select");
    endtask : wait_run

    // one-cycle synchronous request, RAM write attempted while in reset
    task automatic sync_src(input int idx);
        mess_up(8'hA0 + 8'(idx));
        @(posedge clk_sys_in);
        set_src(idx, 1'b1);
        @(posedge clk_sys_in);
        set_src(idx, 1'b0);
        ram_we <= 1'b1;
        ram_wdata <= 8'h3C;
        #1;
        chk(halt === 1'b1, "core halted");
        chk(prst_n === 1'b0 && por_n === 1'b1, "module reset only");
        chk(irq_dis === 1'b1, "irq and timers off");
        chk(cause === (8'h01 << idx), "cause bit");
        chk(oe_n === 1'b1 && pin_n === 1'b1, "pin left alone");
        chk(force_def === 1'b1, "ports forced");
        @(posedge clk_sys_in);
        ram_we <= 1'b0;
        wait_run();
        chk(ram === 8'hA0 + 8'(idx), "ram kept");
    endtask : sync_src

    // asynchronous source held five clocks
    task automatic async_src(input int idx);
        @(posedge clk_sys_in);
        set_src(idx, 1'b1);
        repeat (5) @(posedge clk_sys_in);
        set_src(idx, 1'b0);
        #1;
        chk(halt === 1'b1 && cause === (8'h01 << idx), "async reset taken");
        chk(oe_n === (idx != `RSTC_SRC_SMON), "pin drive select");
        if (idx == `RSTC_SRC_SMON) chk(pin_n === 1'b0, "pin pulled low");
        wait_run();
    endtask : async_src

    task automatic retain_por;
        @(posedge clk_sys_in);
        retain <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sw <= 1'b1;
        @(posedge clk_sys_in);
        sw <= 1'b0;
        #1;
        chk(ana_ret === 1'b1 && force_def === 1'b0, "state retained");
        wait_run();
        @(posedge clk_sys_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk(force_def === 1'b1 && ana_ret === 1'b0, "power-on restores");
        chk(por_n === 1'b0 && pin_n === 1'b0 && cause === `RSTC_CAUSE_POR, "power-on");
        chk(latch_def === 8'hFF && od === 1'b1 && pu === 1'b1, "port defaults");
        retain <= 1'b0;
        nrst_in <= 1'b1;
        wait_run();
    endtask : retain_por

    // long software request with a watchdog overflow inside it
    task automatic overlap;
        @(posedge clk_sys_in);
        sw <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        wdog <= 1'b1;
        @(posedge clk_sys_in);
        wdog <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        sw <= 1'b0;
        #1;
        chk(halt === 1'b1 && prst_n === 1'b0 && cause === 8'h28, "held while any");
        @(posedge clk_sys_in);
        #1;
        chk(halt === 1'b1, "halt through exit");
        wait_run();
    endtask : overlap

    initial begin
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk(halt === 1'b1 && oe_n === 1'b0 && cause === `RSTC_CAUSE_POR, "por state");
        nrst_in <= 1'b1;
        wait_run();
        foreach (sync_ids[i]) sync_src(sync_ids[i]);
        foreach (async_ids[i]) async_src(async_ids[i]);
        retain_por();
        overlap();
        final_report();
    end

    // limit is far above the hundred or so cycles the tasks need
    initial begin
        #2000000;
        fails++;
        final_report();
    end
endmodule : tb
